// *** racr_checker.sv ***
// Assertion checker for the analog control register bank
`timescale 1ns/1ps
module racr_checker
	import racr_pkg::*;
(
	input wire logic         clk,
	input wire logic         reset,
	input wire logic         protected_wr,
	input wire logic         ext_amp_control_pin,
	input wire logic         amp_output_enable,
	input wire logic         device_reset,
	input wire logic         mid_read_enable,
	input wire racr_req_type req,
	input wire logic [7:0]   rdata,
	input wire logic [6:0]   synth_channel,
	input wire logic [11:0]  synth_freq_mhz
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Control register write with reset bit b
	sequence s_wa(bit b);
		req.wr && req.addr == RACR_ADDR_ANALOG_CONTROL
			&& req.wdata[RACR_BIT_SOFT_RESET] == b && !device_reset;
	endsequence

	// One-cycle reset pulse, then channel back to zero
	sequence s_pulse;
		device_reset ##1 (!device_reset && synth_channel == 7'h00);
	endsequence

	property p_pw;
		protected_wr |-> req.wr && (req.addr == RACR_ADDR_PROTECTED_A
			|| req.addr == RACR_ADDR_PROTECTED_B);
	endproperty
	a_pw: assert property (p_pw) else $error("bad protect");

	property p_oe;
		!amp_output_enable |-> !ext_amp_control_pin;
	endproperty
	a_oe: assert property (p_oe) else $error("pin on");

	property p_en;
		s_wa(0) |=> amp_output_enable == $past(req.wdata[RACR_BIT_AMP_OUTPUT_EN])
			&& mid_read_enable == $past(req.wdata[RACR_BIT_MID_READ_ENABLE]);
	endproperty
	a_en: assert property (p_en) else $error("bad enable");

	property p_mid;
		req.rd && req.addr >= RACR_ADDR_MID_FIRST && req.addr <= RACR_ADDR_MID_LAST
			&& !mid_read_enable |=> rdata == 8'h00;
	endproperty
	a_mid: assert property (p_mid) else $error("id leak");

	property p_sr;
		s_wa(1) |=> s_pulse;
	endproperty
	a_sr: assert property (p_sr) else $error("bad reset");

	property p_ch;
		req.wr && req.addr == RACR_ADDR_CHANNEL_SELECT && !device_reset
			|=> synth_channel == $past(req.wdata[6:0]);
	endproperty
	a_ch: assert property (p_ch) else $error("bad channel");

	property p_fr;
		synth_freq_mhz == RACR_FREQ_BASE_MHZ + 12'(synth_channel);
	endproperty
	a_fr: assert property (p_fr) else $error("bad freq");

	property p_rb;
		req.rd && req.addr == RACR_ADDR_ANALOG_CONTROL |=> !rdata[RACR_BIT_SOFT_RESET];
	endproperty
	a_rb: assert property (p_rb) else $error("reset bit set");
endmodule // racr_checker
bind racr_regs racr_checker u_chk (
	.clk                 (clk),
	.reset               (reset),
	.protected_wr        (protected_wr),
	.ext_amp_control_pin (ext_amp_control_pin),
	.amp_output_enable   (amp_output_enable),
	.device_reset        (device_reset),
	.mid_read_enable     (mid_read_enable),
	.req                 (req),
	.rdata               (rdata),
	.synth_channel       (synth_channel),
	.synth_freq_mhz      (synth_freq_mhz)
);

// *** racr_host.sv ***
// Host model issuing register requests
`timescale 1ns/1ps
module racr_host
	import racr_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   protected_wr,
	output racr_req_type req
);
	logic pw_seen;
	initial req = '0;
	task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
		@(posedge clk) req <= '{a, w, !w, d};
		@(negedge clk) pw_seen = protected_wr;
		@(posedge clk) req <= '0;
	endtask
endmodule // racr_host

// *** racr_pkg.sv ***
// Package for the analog control and channel register bank
package racr_pkg;
	localparam logic [5:0] RACR_ADDR_ANALOG_CONTROL  = 6'h20;
	localparam logic [5:0] RACR_ADDR_CHANNEL_SELECT  = 6'h21;
	localparam logic [5:0] RACR_ADDR_PROTECTED_A     = 6'h2e;
	localparam logic [5:0] RACR_ADDR_PROTECTED_B     = 6'h2f;
	localparam logic [5:0] RACR_ADDR_MID_FIRST       = 6'h3c;
	localparam logic [5:0] RACR_ADDR_MID_LAST        = 6'h3f;
	localparam logic [7:0] RACR_ANALOG_RESET_VALUE   = 8'h00;
	localparam logic [7:0] RACR_CHANNEL_RESET_VALUE  = 8'h00;
	localparam logic [7:0] RACR_ANALOG_STORED_MASK   = 8'h66;
	localparam logic [7:0] RACR_CHANNEL_STORED_MASK  = 8'h7f;
	localparam int         RACR_BIT_WRITE_CONTROL    = 6;
	localparam int         RACR_BIT_MID_READ_ENABLE  = 5;
	localparam int         RACR_BIT_AMP_OUTPUT_EN    = 2;
	localparam int         RACR_BIT_AMP_INVERT       = 1;
	localparam int         RACR_BIT_SOFT_RESET       = 0;
	localparam logic [11:0] RACR_FREQ_BASE_MHZ       = 12'h960;

	typedef struct packed {
		logic [5:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} racr_req_type;

	typedef struct packed {
		logic [7:0]  analog_control;
		logic [7:0]  channel_select;
		logic [7:0]  rdata;
		logic        soft_reset;
		logic [11:0] freq_mhz;
	} racr_state_type;
endpackage

// *** racr_regs.sv ***
// Analog control and channel select registers with their side effects
// Operation
// - Write-control bit set lets host writes reach protected registers.
// - Write-control bit clear blocks writes to protected registers.
// - Identifier registers return contents only while read enable is set.
// - Bit 2 enables the external amplifier control pin; clear disables it.
// - Bit 1 set makes amplifier pin active low, clear active high.
// - Writing one to bit 0 resets the whole device; bit self-clears.
// - Seven-bit channel sets synthesizer frequency in 1 MHz steps.
`timescale 1ns/1ps
module racr_regs
	import racr_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire racr_req_type req,
	input  wire logic [31:0]  mid_value,
	input  wire logic         amp_active,
	output logic [7:0]        rdata,
	output logic              protected_wr,
	output logic              mid_read_enable,
	output logic              ext_amp_control_pin,
	output logic              amp_output_enable,
	output logic              device_reset,
	output logic [6:0]        synth_channel,
	output logic [11:0]       synth_freq_mhz
);

	// ----------------------------------------
	// Address decode helpers
	// ----------------------------------------
	function automatic logic is_analog(input logic [5:0] a);
		return a == RACR_ADDR_ANALOG_CONTROL;
	endfunction

	function automatic logic is_channel(input logic [5:0] a);
		return a == RACR_ADDR_CHANNEL_SELECT;
	endfunction

	function automatic logic is_protected(input logic [5:0] a);
		return (a == RACR_ADDR_PROTECTED_A) || (a == RACR_ADDR_PROTECTED_B);
	endfunction

	function automatic logic is_mid(input logic [5:0] a);
		return (a >= RACR_ADDR_MID_FIRST) && (a <= RACR_ADDR_MID_LAST);
	endfunction

	function automatic logic [1:0] mid_slot(input logic [5:0] a);
		// Byte index within the identifier block
		return a[1:0] - RACR_ADDR_MID_FIRST[1:0];
	endfunction

	// ----------------------------------------
	// Data helpers
	// ----------------------------------------
	function automatic logic ctrl_bit(input logic [7:0] r, input int b);
		// Single control bit
		return r[b];
	endfunction

	function automatic logic [7:0] stored_analog(input logic [7:0] d);
		return d & RACR_ANALOG_STORED_MASK;
	endfunction

	function automatic logic [7:0] stored_channel(input logic [7:0] d);
		return d & RACR_CHANNEL_STORED_MASK;
	endfunction

	function automatic logic [11:0] freq_of(input logic [7:0] ch);
		// Fixed offset from channel zero
		return RACR_FREQ_BASE_MHZ + {5'h00, ch[6:0]};
	endfunction

	function automatic logic [7:0] mid_byte(input logic [31:0] v, input logic [1:0] i);
		return v[{i, 3'h0} +: 8];
	endfunction

	function automatic logic amp_level(input logic en, input logic act, input logic inv);
		return en && (act ^ inv);
	endfunction

	function automatic racr_state_type default_state();
		racr_state_type s;
		s.analog_control = RACR_ANALOG_RESET_VALUE;
		s.channel_select = RACR_CHANNEL_RESET_VALUE;
		s.rdata          = '0;
		s.soft_reset     = 1'b0;
		s.freq_mhz       = RACR_FREQ_BASE_MHZ;
		return s;
	endfunction

	// ----------------------------------------
	// State and request decode
	// ----------------------------------------
	racr_state_type state;
	racr_state_type next_state;
	logic [1:0]     mid_index;
	logic [7:0]     mid_data;
	logic           wr_analog;
	logic           wr_channel;
	logic           wr_protected;
	logic           rd_analog;
	logic           rd_channel;
	logic           rd_mid;
	logic           mid_open;
	logic           write_open;
	logic           amp_invert;

	// Write strobes
	// analog and channel writes dropped during soft reset
	assign wr_analog    = req.wr && is_analog(req.addr) && !state.soft_reset;
	assign wr_channel   = req.wr && is_channel(req.addr) && !state.soft_reset;
	assign wr_protected = req.wr && is_protected(req.addr);

	// Read strobes
	assign rd_analog    = req.rd && is_analog(req.addr);
	assign rd_channel   = req.rd && is_channel(req.addr);
	assign rd_mid       = req.rd && is_mid(req.addr);

	// Identifier byte for the current read
	assign mid_index    = mid_slot(req.addr);
	assign mid_data     = mid_byte(mid_value, mid_index);

	assign mid_open   = ctrl_bit(state.analog_control, RACR_BIT_MID_READ_ENABLE);
	assign write_open = ctrl_bit(state.analog_control, RACR_BIT_WRITE_CONTROL);
	assign amp_invert = ctrl_bit(state.analog_control, RACR_BIT_AMP_INVERT);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_state.soft_reset = 1'b0;

		// Write path
		if (state.soft_reset) begin
			next_state.analog_control = RACR_ANALOG_RESET_VALUE;
			next_state.channel_select = RACR_CHANNEL_RESET_VALUE;
		end else begin
			if (wr_analog) begin
				next_state.analog_control = stored_analog(req.wdata);
				next_state.soft_reset = req.wdata[RACR_BIT_SOFT_RESET];
			end
			if (wr_channel) begin
				next_state.channel_select = stored_channel(req.wdata);
			end
		end
		next_state.freq_mhz = freq_of(next_state.channel_select);

		// Read path
		if (req.rd) begin
			if (rd_analog) begin
				next_state.rdata = state.analog_control;
			end else if (rd_channel) begin
				next_state.rdata = state.channel_select;
			end else if (rd_mid && mid_open) begin
				next_state.rdata = mid_data;
			end else begin
				next_state.rdata = '0;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		// Synchronous reset to defaults
		if (reset) begin
			state <= default_state();
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Read port and device reset
	// ----------------------------------------
	assign rdata        = state.rdata;
	assign device_reset = state.soft_reset;

	// ----------------------------------------
	// Synthesizer
	// ----------------------------------------
	// channel and frequency
	assign synth_channel  = state.channel_select[6:0];
	assign synth_freq_mhz = state.freq_mhz;

	// ----------------------------------------
	// Identifier store
	// ----------------------------------------
	// store read enable
	assign mid_read_enable = mid_open;

	// ----------------------------------------
	// Protected registers
	// ----------------------------------------
	// protected write gate
	assign protected_wr = wr_protected && write_open;

	// ----------------------------------------
	// Amplifier pin
	// ----------------------------------------
	// amplifier pin enable
	assign amp_output_enable = ctrl_bit(state.analog_control, RACR_BIT_AMP_OUTPUT_EN);
	assign ext_amp_control_pin = amp_level(amp_output_enable, amp_active,
		amp_invert);

endmodule // racr_regs

// *** tb_top.sv ***
// Self-checking bench for the analog control register bank
`timescale 1ns/1ps
module tb_top
	import racr_pkg::*;
;
	logic         clk        = 1'h0;
	logic         reset      = 1'h1;
	logic         amp_active = 1'h0;
	logic         protected_wr;
	logic         mid_read_enable;
	logic         ext_amp_control_pin;
	logic         amp_output_enable;
	logic         device_reset;
	logic [31:0]  mid_value  = 32'h12345678;
	logic [7:0]   rdata;
	logic [6:0]   synth_channel;
	logic [11:0]  synth_freq_mhz;
	racr_req_type req;
	int           failures   = 0;
	int           compares   = 0;
	int           cyc        = 0;
	racr_host u_host (
		.clk          (clk),
		.protected_wr (protected_wr),
		.req          (req)
	);
	racr_regs DUT (
		.clk                 (clk),
		.reset               (reset),
		.req                 (req),
		.mid_value           (mid_value),
		.amp_active          (amp_active),
		.rdata               (rdata),
		.protected_wr        (protected_wr),
		.mid_read_enable     (mid_read_enable),
		.ext_amp_control_pin (ext_amp_control_pin),
		.amp_output_enable   (amp_output_enable),
		.device_reset        (device_reset),
		.synth_channel       (synth_channel),
		.synth_freq_mhz      (synth_freq_mhz)
	);
	initial forever #10 clk = ~clk;
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [5:0] a, input logic [7:0] e);
		u_host.acc(a, 1'h0, 8'h00);
		#1 chk(12'(rdata), 12'(e));
	endtask
	task automatic wc(input logic [5:0] a, input logic [7:0] d);
		u_host.acc(a, 1'h1, d);
		#1;
	endtask
	task conclude;
		$display("Compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 32'h00000bb8) begin
		failures++;
		conclude;
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		rc(6'h20, 8'h00);
		rc(6'h21, 8'h00);
		wc(6'h21, 8'h4f);
		chk(12'(synth_channel), 12'h04f);
		chk(synth_freq_mhz, 12'h9af);
		rc(6'h21, 8'h4f);
		wc(6'h20, 8'h04);
		chk(12'(amp_output_enable), 12'h001);
		chk(12'(ext_amp_control_pin), 12'h000);
		wc(6'h20, 8'h06);
		chk(12'(ext_amp_control_pin), 12'h001);
		@(posedge clk) amp_active <= 1'h1;
		#1 chk(12'(ext_amp_control_pin), 12'h000);
		wc(6'h20, 8'h26);
		chk(12'(mid_read_enable), 12'h001);
		rc(6'h3f, 8'h12);
		wc(6'h20, 8'h06);
		chk(12'(mid_read_enable), 12'h000);
		rc(6'h3c, 8'h00);
		wc(6'h20, 8'h46);
		wc(6'h2e, 8'h5a);
		chk(12'(u_host.pw_seen), 12'h001);
		wc(6'h20, 8'h06);
		wc(6'h2f, 8'h5a);
		chk(12'(u_host.pw_seen), 12'h000);
		rc(6'h30, 8'h00);
		rc(6'h20, 8'h06);
		wc(6'h20, 8'h07);
		chk(12'(device_reset), 12'h001);
		rc(6'h20, 8'h00);
		chk(12'(device_reset), 12'h000);
		rc(6'h21, 8'h00);
		chk(synth_freq_mhz, 12'h960);
		chk(12'(amp_output_enable), 12'h000);
		chk(12'(ext_amp_control_pin), 12'h000);
		conclude;
	end
endmodule // tb_top
